// ===== hw/rdrs_pkg.sv
package rdrs_pkg;
  localparam int unsigned RING_MAX       = 128;
  localparam int unsigned IDX_W          = 7;
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned WORDS_PER_DESC = 4;
  localparam int unsigned DESC_BYTES_SH  = 3;
  localparam logic [ADDR_W-1:0] OFS_WORD0 = 24'h00_0000;
  localparam logic [ADDR_W-1:0] OFS_WORD3 = 24'h00_0006;
  localparam int unsigned BIT_OWN        = 15;
  localparam int unsigned BIT_RING_END   = 14;
  localparam int unsigned BIT_CR         = 13;
  localparam int unsigned BIT_LAST       = 12;
  localparam int unsigned BIT_FIELD_HI   = 11;
  localparam int unsigned BIT_FIELD_LO   = 9;
  localparam int unsigned BIT_ERR        = 8;
  localparam int unsigned ADDR_HI_MSB    = 7;
  localparam logic [IDX_W-1:0] IDX_RESET = 7'h00;
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned POLL_NS        = 1000;
  localparam int unsigned POLL_CYC       = (POLL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POLL_W         = 8;
endpackage

// ===== hw/rdrs_ring_ctrl.sv
`timescale 1ns/10ps
module rdrs_ring_ctrl #(
  parameter int unsigned CHAN_W = 13
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Ring setup from host side
  input  wire logic                        cfg_we,
  input  wire logic [CHAN_W-1:0]           cfg_chan,
  input  wire logic [rdrs_pkg::ADDR_W-1:0] cfg_base,
  output logic                             cfg_ready_ff,
  // Receive buffer completion from the framer
  input  wire logic                        rx_req,
  input  wire logic [CHAN_W-1:0]           rx_chan,
  input  wire logic                        rx_mgmt,
  input  wire logic                        rx_cr,
  input  wire logic                        rx_forward_congestion_bit,
  input  wire logic                        rx_backward_congestion_bit,
  input  wire logic                        rx_de,
  input  wire logic [2:0]                  rx_frame_type,
  input  wire logic                        rx_bad,
  input  wire logic                        rx_last,
  input  wire logic [15:0]                 rx_msg_count,
  input  wire logic                        bad_frame_receive_enable,
  output logic                             rx_ready_ff,
  output logic                             rx_done_ff,
  output logic                             rx_dropped_ff,
  output logic                             rx_waiting_ff,
  // Shared memory word port
  output logic                             mem_req_ff,
  output logic                             mem_we_ff,
  output logic [rdrs_pkg::ADDR_W-1:0]      mem_addr_ff,
  output logic [15:0]                      mem_wdata_ff,
  input  wire logic [15:0]                 mem_rdata,
  input  wire logic                        mem_ack
);
  import rdrs_pkg::*;

  localparam int unsigned ENT_W = ADDR_W + IDX_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STATE, ST_FETCH, ST_CHECK, ST_POLL, ST_WR3, ST_WR0, ST_ADV
  } rdrs_state_t;

  rdrs_state_t         state_ff;
  rdrs_state_t         nxt_state;
  logic [CHAN_W-1:0]   chan_ff;
  logic                mgmt_ff;
  logic                cr_ff;
  logic [2:0]          field_ff;
  logic                bad_ff;
  logic                last_ff;
  logic [15:0]         cnt_ff;
  logic [15:0]         word0_ff;
  logic [ADDR_W-1:0]   base_ff;
  logic [IDX_W-1:0]    idx_ff;
  logic [POLL_W-1:0]   poll_ff;
  logic [ENT_W-1:0]    ent_rd;
  logic                mem_wr_en;
  logic [CHAN_W-1:0]   mem_wr_addr;
  logic [ENT_W-1:0]    mem_wr_data;
  logic [IDX_W-1:0]    nxt_idx;
  logic [15:0]         nxt_word0;
  logic                accept;
  logic                discard;

  // Descriptor byte address from ring base and entry index
  function automatic logic [ADDR_W-1:0] desc_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [IDX_W-1:0]  idx,
                                                  input logic [ADDR_W-1:0] ofs);
    logic [ADDR_W-1:0] step;
    step = ADDR_W'({idx, DESC_BYTES_SH'(0)});
    return base + step + ofs;
  endfunction

  assign accept  = (state_ff == ST_IDLE) && rx_req;
  assign discard = rx_bad && !bad_frame_receive_enable;

  // One state entry per channel keeps rings apart
  rdrs_state_mem #(
    .AW (CHAN_W),
    .DW (ENT_W)
  ) u_state_mem (
    .clk        (clk),
    .wr_en      (mem_wr_en),
    .wr_addr    (mem_wr_addr),
    .wr_data    (mem_wr_data),
    .rd_en      (accept),
    .rd_addr    (rx_chan),
    .rd_data_ff (ent_rd)
  );

  always_comb
  begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = chan_ff;
    mem_wr_data = {base_ff, nxt_idx};
    if (state_ff == ST_ADV)
    begin
      mem_wr_en = 1'b1;
    end
    else if (state_ff == ST_IDLE && cfg_we && !rx_req)
    begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = cfg_chan;
      mem_wr_data = {cfg_base, IDX_RESET};
    end
  end

  // Wrap on ring end or at the largest ring size
  always_comb
  begin
    if (word0_ff[BIT_RING_END] || idx_ff == IDX_W'(RING_MAX - 1))
    begin
      nxt_idx = IDX_RESET;
    end
    else
    begin
      nxt_idx = idx_ff + IDX_W'(1);
    end
  end

  // Compose first word; host fields kept as fetched
  always_comb
  begin
    nxt_word0 = word0_ff;
    nxt_word0[BIT_OWN]  = 1'b0;
    nxt_word0[BIT_CR]   = mgmt_ff ? 1'b0 : cr_ff;
    nxt_word0[BIT_LAST] = last_ff;
    nxt_word0[BIT_FIELD_HI:BIT_FIELD_LO] = field_ff;
    nxt_word0[BIT_ERR]  = bad_ff;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (rx_req && !discard)
        begin
          nxt_state = ST_STATE;
        end
      end
      ST_STATE:
      begin
        nxt_state = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (mem_ack)
        begin
          nxt_state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (!word0_ff[BIT_OWN])
        begin
          nxt_state = ST_POLL;
        end
        else if (last_ff)
        begin
          nxt_state = ST_WR3;
        end
        else
        begin
          nxt_state = ST_WR0;
        end
      end
      ST_POLL:
      begin
        if (poll_ff == POLL_W'(0))
        begin
          nxt_state = ST_FETCH;
        end
      end
      ST_WR3:
      begin
        if (mem_ack)
        begin
          nxt_state = ST_WR0;
        end
      end
      ST_WR0:
      begin
        if (mem_ack)
        begin
          nxt_state = ST_ADV;
        end
      end
      ST_ADV:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Frame status captured at acceptance
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      chan_ff  <= '0;
      mgmt_ff  <= 1'b0;
      cr_ff    <= 1'b0;
      field_ff <= 3'h0;
      bad_ff   <= 1'b0;
      last_ff  <= 1'b0;
      cnt_ff   <= 16'h0000;
    end
    else if (accept)
    begin
      chan_ff  <= rx_chan;
      mgmt_ff  <= rx_mgmt;
      cr_ff    <= rx_cr;
      field_ff <= rx_mgmt ? rx_frame_type : {rx_forward_congestion_bit, rx_backward_congestion_bit, rx_de};
      bad_ff   <= rx_bad;
      last_ff  <= rx_last;
      cnt_ff   <= rx_msg_count;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      base_ff <= '0;
      idx_ff  <= IDX_RESET;
    end
    else if (state_ff == ST_STATE)
    begin
      base_ff <= ent_rd[ENT_W-1:IDX_W];
      idx_ff  <= ent_rd[IDX_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      word0_ff <= 16'h0000;
    end
    else if (state_ff == ST_FETCH && mem_ack)
    begin
      word0_ff <= mem_rdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      poll_ff <= '0;
    end
    else if (state_ff == ST_CHECK)
    begin
      poll_ff <= POLL_W'(POLL_CYC - 1);
    end
    else if (state_ff == ST_POLL && poll_ff != POLL_W'(0))
    begin
      poll_ff <= poll_ff - POLL_W'(1);
    end
  end

  // Memory port: word0 read, optional word3 write, word0 write; words one and two never touched
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= 16'h0000;
    end
    else if (mem_req_ff && !mem_ack)
    begin
      mem_req_ff <= 1'b1;
    end
    else
    begin
      mem_req_ff <= 1'b0;
      mem_we_ff  <= 1'b0;
      if (nxt_state == ST_FETCH && state_ff != ST_FETCH)
      begin
        mem_req_ff  <= 1'b1;
        mem_addr_ff <= (state_ff == ST_STATE) ? desc_addr(ent_rd[ENT_W-1:IDX_W], ent_rd[IDX_W-1:0], OFS_WORD0)
                                              : desc_addr(base_ff, idx_ff, OFS_WORD0);
      end
      else if (nxt_state == ST_WR3 && state_ff != ST_WR3)
      begin
        mem_req_ff   <= 1'b1;
        mem_we_ff    <= 1'b1;
        mem_addr_ff  <= desc_addr(base_ff, idx_ff, OFS_WORD3);
        mem_wdata_ff <= cnt_ff;
      end
      else if (nxt_state == ST_WR0 && state_ff != ST_WR0)
      begin
        mem_req_ff   <= 1'b1;
        mem_we_ff    <= 1'b1;
        mem_addr_ff  <= desc_addr(base_ff, idx_ff, OFS_WORD0);
        mem_wdata_ff <= nxt_word0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_ready_ff   <= 1'b0;
      cfg_ready_ff  <= 1'b0;
      rx_done_ff    <= 1'b0;
      rx_dropped_ff <= 1'b0;
      rx_waiting_ff <= 1'b0;
    end
    else
    begin
      rx_ready_ff   <= (nxt_state == ST_IDLE);
      cfg_ready_ff  <= (nxt_state == ST_IDLE);
      rx_done_ff    <= (state_ff == ST_ADV);
      rx_dropped_ff <= accept && discard;
      rx_waiting_ff <= (nxt_state == ST_POLL);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_word0_write;
    mem_req_ff && mem_we_ff && state_ff == ST_WR0;
  endsequence

  sequence s_host_owned;
    state_ff == ST_CHECK && !word0_ff[BIT_OWN];
  endsequence

  a_own_wait_poll: assert property (s_host_owned |=> state_ff == ST_POLL && !mem_req_ff)
    else $error("Host owned descriptor was not left alone");
  a_poll_refetch: assert property (s_host_owned |-> ##[2:40] (state_ff == ST_FETCH && mem_req_ff && !mem_we_ff))
    else $error("Descriptor not fetched again after poll wait");
  a_own_release: assert property (s_word0_write |-> !mem_wdata_ff[BIT_OWN])
    else $error("Word0 written without releasing ownership");
  a_host_bits_kept: assert property (s_word0_write |-> mem_wdata_ff[ADDR_HI_MSB:0] == word0_ff[ADDR_HI_MSB:0]
                                     && mem_wdata_ff[BIT_RING_END] == word0_ff[BIT_RING_END])
    else $error("Host written bits of word0 changed");
  a_mgmt_cr_zero: assert property (s_word0_write and mgmt_ff |-> !mem_wdata_ff[BIT_CR])
    else $error("Management reserved bit written nonzero");
  a_err_flag_bit: assert property (s_word0_write |-> mem_wdata_ff[BIT_ERR] == bad_ff
                                   && mem_wdata_ff[BIT_LAST] == last_ff)
    else $error("Error or last flag wrong in word0");
  a_count_on_last: assert property (mem_req_ff && mem_we_ff && mem_addr_ff == desc_addr(base_ff, idx_ff, OFS_WORD3)
                                    |-> last_ff && mem_wdata_ff == cnt_ff)
    else $error("Message count written for a chained buffer");
  a_ring_wrap: assert property (state_ff == ST_ADV && word0_ff[BIT_RING_END] |-> mem_wr_data[IDX_W-1:0] == IDX_RESET)
    else $error("Ring did not wrap after ring end");
  a_bad_discard: assert property (accept && discard |=> state_ff == ST_IDLE && rx_dropped_ff)
    else $error("Bad frame not discarded while disabled");
  a_ordinary_bits: assert property (s_word0_write and !mgmt_ff |-> mem_wdata_ff[BIT_CR] == cr_ff)
    else $error("Command response bit not copied");
endmodule

// ===== hw/rdrs_state_mem.sv
`timescale 1ns/10ps
module rdrs_state_mem #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 31
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data registered
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_ff
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule

// ===== verif/rdrs_host_mem.sv
`timescale 1ns/10ps
module rdrs_host_mem (
  // Clock
  input  wire logic        clk,
  // Word port from the engine
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  // Answer delay in cycles, and count of accesses the engine must not make
  input  wire logic [3:0]  lat,
  output logic      [7:0]  stray_cnt
);
  logic [15:0] mem [0:2047];
  logic [3:0]  wait_cnt;

  initial
  begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h0000;
    wait_cnt  = 4'h0;
    stray_cnt = 8'h00;
  end

  always @(posedge clk)
  begin
    mem_ack   <= 1'b0;
    // Read data is garbage outside an answer cycle
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (wait_cnt < lat)
        wait_cnt <= wait_cnt + 4'h1;
      else
      begin
        wait_cnt <= 4'h0;
        mem_ack  <= 1'b1;
        if (mem_we)
          mem[mem_addr[11:1]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[11:1]];
        // Words one and two belong to the host alone
        if (mem_addr[2:1] == 2'b01 || mem_addr[2:1] == 2'b10)
          stray_cnt <= stray_cnt + 8'h01;
        // A host owned descriptor must not be written
        else if (mem_we && !mem[{mem_addr[11:3], 2'b00}][15])
          stray_cnt <= stray_cnt + 8'h01;
      end
    end
  end
endmodule

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  import rdrs_pkg::*;
  logic        clk, sys_rst, cfg_we, cfg_ready_ff, rx_req, rx_mgmt, rx_cr, rx_forward_congestion_bit, rx_backward_congestion_bit, rx_de;
  logic        rx_bad, rx_last, bfre, rx_ready_ff, rx_done_ff, rx_dropped_ff, rx_waiting_ff;
  logic        mem_req_ff, mem_we_ff, mem_ack;
  logic [3:0]  cfg_chan, rx_chan, lat;
  logic [2:0]  rx_frame_type;
  logic [23:0] cfg_base, mem_addr_ff, e_a;
  logic [15:0] rx_msg_count, mem_wdata_ff, mem_rdata, e_w0, e_w3, w;
  logic [7:0]  stray_cnt;
  logic        e_drop;
  int          miscompares, checks_done, i;

  rdrs_ring_ctrl #(.CHAN_W(4)) rdrs_ring_ctrl_i (.clk(clk), .sys_rst(sys_rst), .cfg_we(cfg_we),
    .cfg_chan(cfg_chan), .cfg_base(cfg_base), .cfg_ready_ff(cfg_ready_ff), .rx_req(rx_req), .rx_chan(rx_chan),
    .rx_mgmt(rx_mgmt), .rx_cr(rx_cr), .rx_forward_congestion_bit(rx_forward_congestion_bit), .rx_backward_congestion_bit(rx_backward_congestion_bit), .rx_de(rx_de),
    .rx_frame_type(rx_frame_type), .rx_bad(rx_bad), .rx_last(rx_last), .rx_msg_count(rx_msg_count),
    .bad_frame_receive_enable(bfre), .rx_ready_ff(rx_ready_ff), .rx_done_ff(rx_done_ff),
    .rx_dropped_ff(rx_dropped_ff), .rx_waiting_ff(rx_waiting_ff), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  rdrs_host_mem rdrs_host_mem_i (.clk(clk), .mem_req(mem_req_ff), .mem_we(mem_we_ff), .mem_addr(mem_addr_ff),
    .mem_wdata(mem_wdata_ff), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat), .stray_cnt(stray_cnt));

  always #25 clk = ~clk;

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    miscompares++;
    $display("BAD %0t engine did not answer", $time);
    give_verdict();
  endtask

  // Host builds one descriptor: four words, two bytes apart
  task automatic setd(input logic [23:0] a, input logic own, input logic ring_end_flag);
    rdrs_host_mem_i.mem[a[11:1]]         = {own, ring_end_flag, 6'h00, a[10:3] ^ 8'hA5};
    rdrs_host_mem_i.mem[a[11:1] + 11'd1] = 16'h1234;
    rdrs_host_mem_i.mem[a[11:1] + 11'd2] = 16'hFFF0;
    rdrs_host_mem_i.mem[a[11:1] + 11'd3] = 16'h5555;
  endtask

  task automatic cfg(input logic [3:0] ch, input logic [23:0] base);
    @(negedge clk);
    cfg_we   = 1'b1;
    cfg_chan = ch;
    cfg_base = base;
    @(negedge clk);
    cfg_we   = 1'b0;
  endtask

  // Offers one filled buffer and works out the descriptor it must leave behind
  task automatic go(input logic [23:0] a, input logic [3:0] ch, input logic mg, input logic cr,
                    input logic [2:0] fld, input logic bad, input logic last, input logic en, input logic drop);
    int n;
    n = 0;
    while (rx_ready_ff !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
      tmo();
    e_a    = a;
    e_drop = drop;
    w      = rdrs_host_mem_i.mem[a[11:1]];
    e_w3   = rdrs_host_mem_i.mem[a[11:1] + 11'd3];
    e_w0   = drop ? w : {1'b0, w[14], cr & ~mg, last, fld, bad, w[7:0]};
    if (!drop && last)
      e_w3 = {4'hE, a[11:0]};
    rx_req        = 1'b1;
    rx_chan       = ch;
    rx_mgmt       = mg;
    rx_cr         = cr;
    {rx_forward_congestion_bit, rx_backward_congestion_bit, rx_de} = mg ? ~fld : fld;
    rx_frame_type = mg ? fld : ~fld;
    rx_bad        = bad;
    rx_last       = last;
    bfre          = en;
    rx_msg_count  = {4'hE, a[11:0]};
    @(negedge clk);
    rx_req        = 1'b0;
  endtask

  task automatic fin();
    int n;
    n = 0;
    while (rx_done_ff !== 1'b1 && rx_dropped_ff !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
      tmo();
    chk({15'h0000, rx_dropped_ff}, {15'h0000, e_drop});
    @(negedge clk);
    chk(rdrs_host_mem_i.mem[e_a[11:1]], e_w0);
    chk(rdrs_host_mem_i.mem[e_a[11:1] + 11'd3], e_w3);
  endtask

  task automatic post(input logic [23:0] a, input logic [3:0] ch, input logic mg, input logic cr,
                      input logic [2:0] fld, input logic bad, input logic last, input logic en, input logic drop);
    go(a, ch, mg, cr, fld, bad, last, en, drop);
    fin();
  endtask

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {cfg_we, rx_req, rx_mgmt, rx_cr, rx_forward_congestion_bit, rx_backward_congestion_bit, rx_de, rx_bad, rx_last, bfre} = 10'h000;
    {cfg_chan, rx_chan, lat, rx_frame_type} = 15'h0000;
    cfg_base = 24'h00_0000;
    rx_msg_count = 16'h0000;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(negedge clk);
    chk({15'h0000, rx_ready_ff}, 16'h0000);
    chk({15'h0000, mem_req_ff}, 16'h0000);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk({14'h0000, rx_ready_ff, cfg_ready_ff}, 16'h0003);
    // Channel 3: 128 entries at 0, channel 1: 3 at 0x400, channel 2: 8 at 0x500
    for (i = 0; i < 128; i++)
      setd(24'(i * 8), 1'b1, 1'b0);
    for (i = 0; i < 8; i++)
      setd(24'h00_0500 + 24'(i * 8), 1'b1, i == 7);
    for (i = 0; i < 3; i++)
      setd(24'h00_0400 + 24'(i * 8), 1'b1, i == 2);
    cfg(4'h3, 24'h00_0000);
    cfg(4'h1, 24'h00_0400);
    cfg(4'h2, 24'h00_0500);
    post(24'h00_0400, 4'h1, 1'b0, 1'b1, 3'b101, 1'b0, 1'b1, 1'b0, 1'b0);
    // Management frame types on channel 2, slow memory, between channel 1 frames
    for (i = 0; i < 8; i++)
    begin
      lat = 4'(i % 3);
      post(24'h00_0500 + 24'(i * 8), 4'h2, 1'b1, 1'b1, 3'(i), 1'b0, i[0], 1'b0, 1'b0);
    end
    lat = 4'h0;
    post(24'h00_0408, 4'h1, 1'b0, 1'b0, 3'b010, 1'b0, 1'b0, 1'b0, 1'b0);
    post(24'h00_0410, 4'h1, 1'b0, 1'b1, 3'b111, 1'b1, 1'b1, 1'b0, 1'b1);
    post(24'h00_0410, 4'h1, 1'b0, 1'b1, 3'b011, 1'b1, 1'b1, 1'b1, 1'b0);
    // Wrap to entry 0 which the host still owns
    go(24'h00_0400, 4'h1, 1'b0, 1'b0, 3'b110, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (60) @(negedge clk);
    chk({14'h0000, rx_waiting_ff, cfg_ready_ff}, 16'h0002);
    chk(rdrs_host_mem_i.mem[11'h200], w);
    rdrs_host_mem_i.mem[11'h200][15] = 1'b1;
    fin();
    for (i = 0; i < 128; i++)
      post(24'(i * 8), 4'h3, 1'b0, i[1], 3'(i), 1'b0, 1'b1, 1'b0, 1'b0);
    setd(24'h00_0000, 1'b1, 1'b0);
    post(24'h00_0000, 4'h3, 1'b0, 1'b1, 3'b100, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({8'h00, stray_cnt}, 16'h0000);
    give_verdict();
  end
endmodule
